// ---- rtl/port_tag_wake_irq_consts.vh ----
// constants for the per-port tag, wake event and interrupt register slice
//
// Behaviour
// - tag high byte: PCP 7:5, DEI 4, VID 11:8 in 3:0; resets 0x00.
// - tag low byte holds VID 7:0, resets 0x01 so VLAN one.
// - port number in address top nibble; ports 1-3, PHY bits ports 1-2.
// - magic flag bit 2 sets only if destination equals switch MAC.
// - link-up flag bit 1 sets on link rising, PHY ports only.
// - energy flag bit 0 sets on cable energy, PHY ports only.
// - enable bit 2 lets magic packet assert power event output.
// - enable bit 1 lets link-up assert power event output.
// - enable bit 0 lets cable energy assert power event output.
// - PHY status bit 1 reflects pending PHY interrupt, PHY ports only.
// - ACL status bit 0 sets on counter-mode ACL interrupt, all ports.
// - toggling ACL mask bit clears the ACL status bit.
// - mask bits are inverted: zero enables; both reset to zero.
// - status reaches interrupt output only when its mask enables it.
// - entry words three and four carry lookup or static table layout.
// - reading top byte of entry word four clears search-valid flag.
`ifndef PORT_TAG_WAKE_IRQ_CONSTS_VH
`define PORT_TAG_WAKE_IRQ_CONSTS_VH

// ****************************************************************
// port address map
// ****************************************************************
`define PORT_FIRST 4'h1
`define PORT_LAST 4'h3
`define PORT_MAC 4'h3
`define OFS_TAG_HIGH 12'h000
`define OFS_TAG_LOW 12'h001
`define OFS_WAKE_FLAGS 12'h013
`define OFS_WAKE_ENABLE 12'h017
`define OFS_IRQ_STATUS 12'h01B
`define OFS_IRQ_MASK 12'h01F

// ****************************************************************
// table entry words
// ****************************************************************
`define ADDR_ENTRY3 16'h0428
`define ADDR_ENTRY4 16'h042C
`define ADDR_ENTRY4_TOP 16'h042F

// ****************************************************************
// reset values and fields
// ****************************************************************
`define TAG_HIGH_RST 8'h00
`define TAG_LOW_RST 8'h01
`define WAKE_MAGIC_BIT 2
`define WAKE_LINK_BIT 1
`define WAKE_ENERGY_BIT 0
`define WAKE_KEEP_PHY 3'h7
`define WAKE_KEEP_MAC 3'h4
`define IRQ_PHY_BIT 1
`define IRQ_ACL_BIT 0
`define IRQ_KEEP_PHY 2'h3
`define IRQ_KEEP_MAC 2'h1
`define MASK_RST 2'h0

`endif

// ---- rtl/wake_event_slice.v ----
// wake event flags and enables of one port
`timescale 1ns/1ps
`default_nettype none
`include "port_tag_wake_irq_consts.vh"

module wake_event_slice #(
   parameter HAS_PHY = 1
) (
   input wire clock_in,
   input wire arst_n_in,
   input wire ce_in,
   input wire magic_packet_in,
   input wire [47:0] magic_dest_in,
   input wire [47:0] switch_mac_in,
   input wire link_up_in,
   input wire energy_in,
   input wire flags_wr_in,
   input wire enable_wr_in,
   input wire [7:0] wdata_in,
   output reg [2:0] flags_out,
   output reg [2:0] enable_out,
   output wire wake_out
);
   localparam [2:0] KEEP = HAS_PHY ? `WAKE_KEEP_PHY : `WAKE_KEEP_MAC;
   reg link_prev;
   wire [2:0] set;
   wire [2:0] clear;

   assign set[`WAKE_MAGIC_BIT] = magic_packet_in &&
      (magic_dest_in == switch_mac_in);
   assign set[`WAKE_LINK_BIT] = link_up_in & ~link_prev;
   assign set[`WAKE_ENERGY_BIT] = energy_in;
   assign clear = flags_wr_in ? wdata_in[2:0] : 3'h0;
   assign wake_out = |(flags_out & enable_out);

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flags_out <= 3'h0;
         enable_out <= 3'h0;
         link_prev <= 1'b0;
      end else if (ce_in) begin
         link_prev <= link_up_in;
         // set wins over a clear in the same cycle
         flags_out <= ((flags_out & ~clear) | set) & KEEP;
         if (enable_wr_in) begin
            enable_out <= wdata_in[2:0] & KEEP;
         end
      end
   end
endmodule

`default_nettype wire

// ---- rtl/port_irq_slice.v ----
// interrupt status and inverted mask of one port
`timescale 1ns/1ps
`default_nettype none
`include "port_tag_wake_irq_consts.vh"

module port_irq_slice #(
   parameter HAS_PHY = 1
) (
   input wire clock_in,
   input wire arst_n_in,
   input wire ce_in,
   input wire phy_irq_in,
   input wire acl_irq_in,
   input wire mask_wr_in,
   input wire [7:0] wdata_in,
   output reg [1:0] status_out,
   output reg [1:0] mask_out,
   output wire irq_out
);
   localparam [1:0] KEEP = HAS_PHY ? `IRQ_KEEP_PHY : `IRQ_KEEP_MAC;
   wire acl_clear;

   assign acl_clear = mask_wr_in &&
      (wdata_in[`IRQ_ACL_BIT] != mask_out[`IRQ_ACL_BIT]);
   assign irq_out = |(status_out & ~mask_out);

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_out <= 2'h0;
         mask_out <= `MASK_RST;
      end else if (ce_in) begin
         status_out[`IRQ_PHY_BIT] <= phy_irq_in & KEEP[`IRQ_PHY_BIT];
         status_out[`IRQ_ACL_BIT] <= acl_irq_in |
            (status_out[`IRQ_ACL_BIT] & ~acl_clear);
         if (mask_wr_in) begin
            mask_out <= wdata_in[1:0] & KEEP;
         end
      end
   end
endmodule

`default_nettype wire

// ---- rtl/port_tag_wake_irq_regs.v ----
// per-port tag, wake event, interrupt and table entry registers
`timescale 1ns/1ps
`default_nettype none
`include "port_tag_wake_irq_consts.vh"

module port_tag_wake_irq_regs #(
   parameter NUM_PORTS = 3,
   parameter NUM_PHY_PORTS = 2
) (
   input wire clock_in,
   input wire arst_n_in,
   input wire ce_in,
   input wire [15:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [7:0] rdata_out,
   input wire [NUM_PORTS-1:0] magic_packet_in,
   input wire [48*NUM_PORTS-1:0] magic_dest_in,
   input wire [47:0] switch_mac_in,
   input wire [NUM_PORTS-1:0] link_up_in,
   input wire [NUM_PORTS-1:0] energy_in,
   input wire [NUM_PORTS-1:0] phy_irq_in,
   input wire [NUM_PORTS-1:0] acl_irq_in,
   input wire static_table_sel_in,
   input wire engine_load_in,
   input wire [31:0] engine_word3_in,
   input wire [31:0] engine_word4_in,
   input wire search_valid_set_in,
   output reg [31:0] table_entry3_out,
   output reg [31:0] table_entry4_out,
   output reg static_table_out,
   output reg search_valid_out,
   output wire [16*NUM_PORTS-1:0] default_tag_out,
   output wire [3*NUM_PORTS-1:0] pcp_out,
   output wire [NUM_PORTS-1:0] dei_out,
   output wire [12*NUM_PORTS-1:0] vid_out,
   output reg [NUM_PORTS-1:0] port_irq_out,
   output reg irq_out,
   output reg power_event_output_out
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   function [3:0] port_num;
      input integer idx;
      begin
         port_num = idx[3:0] + `PORT_FIRST;
      end
   endfunction

   function hit;
      input [15:0] a;
      input [3:0] n;
      input [11:0] ofs;
      begin
         hit = (a[15:12] == n) && (a[11:0] == ofs);
      end
   endfunction

   function in_word;
      input [15:0] a;
      input [15:0] base;
      begin
         in_word = (a[15:2] == base[15:2]);
      end
   endfunction

   function [7:0] byte_of;
      input [31:0] w;
      input [1:0] idx;
      begin
         if (idx == 2'h0) begin
            byte_of = w[7:0];
         end else if (idx == 2'h1) begin
            byte_of = w[15:8];
         end else if (idx == 2'h2) begin
            byte_of = w[23:16];
         end else begin
            byte_of = w[31:24];
         end
      end
   endfunction

   function [31:0] put_byte;
      input [31:0] w;
      input [1:0] idx;
      input [7:0] b;
      begin
         put_byte = w;
         if (idx == 2'h0) begin
            put_byte[7:0] = b;
         end else if (idx == 2'h1) begin
            put_byte[15:8] = b;
         end else if (idx == 2'h2) begin
            put_byte[23:16] = b;
         end else begin
            put_byte[31:24] = b;
         end
      end
   endfunction

   // ****************************************************************
   // per-port storage and slices
   // ****************************************************************
   reg [7:0] tag_high [0:NUM_PORTS-1];
   reg [7:0] tag_low [0:NUM_PORTS-1];
   wire [3*NUM_PORTS-1:0] wake_flags;
   wire [3*NUM_PORTS-1:0] wake_enable;
   wire [NUM_PORTS-1:0] wake_any;
   wire [2*NUM_PORTS-1:0] irq_status;
   wire [2*NUM_PORTS-1:0] irq_mask;
   wire [NUM_PORTS-1:0] irq_any;
   wire write_ok;
   wire read_ok;
   integer k;
   integer j;

   assign write_ok = ce_in & wr_in;
   assign read_ok = ce_in & rd_in;

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g = g + 1) begin : port_slot
         wire flags_wr;
         wire enable_wr;
         wire mask_wr;

         assign flags_wr = write_ok &&
            hit(addr_in, port_num(g), `OFS_WAKE_FLAGS);
         assign enable_wr = write_ok &&
            hit(addr_in, port_num(g), `OFS_WAKE_ENABLE);
         assign mask_wr = write_ok &&
            hit(addr_in, port_num(g), `OFS_IRQ_MASK);

         // high byte first so the tag reads as one 16-bit word
         assign default_tag_out[16*g+15:16*g] = {tag_high[g], tag_low[g]};
         assign pcp_out[3*g+2:3*g] = tag_high[g][7:5];
         assign dei_out[g] = tag_high[g][4];
         assign vid_out[12*g+11:12*g] = {tag_high[g][3:0], tag_low[g]};

         wake_event_slice #(
            .HAS_PHY(g < NUM_PHY_PORTS)
         ) wake_unit (
            .clock_in(clock_in),
            .arst_n_in(arst_n_in),
            .ce_in(ce_in),
            .magic_packet_in(magic_packet_in[g]),
            .magic_dest_in(magic_dest_in[48*g+47:48*g]),
            .switch_mac_in(switch_mac_in),
            .link_up_in(link_up_in[g]),
            .energy_in(energy_in[g]),
            .flags_wr_in(flags_wr),
            .enable_wr_in(enable_wr),
            .wdata_in(wdata_in),
            .flags_out(wake_flags[3*g+2:3*g]),
            .enable_out(wake_enable[3*g+2:3*g]),
            .wake_out(wake_any[g])
         );

         port_irq_slice #(
            .HAS_PHY(g < NUM_PHY_PORTS)
         ) irq_unit (
            .clock_in(clock_in),
            .arst_n_in(arst_n_in),
            .ce_in(ce_in),
            .phy_irq_in(phy_irq_in[g]),
            .acl_irq_in(acl_irq_in[g]),
            .mask_wr_in(mask_wr),
            .wdata_in(wdata_in),
            .status_out(irq_status[2*g+1:2*g]),
            .mask_out(irq_mask[2*g+1:2*g]),
            .irq_out(irq_any[g])
         );
      end
   endgenerate

   // ****************************************************************
   // default tag registers
   // ****************************************************************
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (k = 0; k < NUM_PORTS; k = k + 1) begin
            tag_high[k] <= `TAG_HIGH_RST;
            tag_low[k] <= `TAG_LOW_RST;
         end
      end else if (write_ok) begin
         for (k = 0; k < NUM_PORTS; k = k + 1) begin
            if (hit(addr_in, port_num(k), `OFS_TAG_HIGH)) begin
               tag_high[k] <= wdata_in;
            end
            if (hit(addr_in, port_num(k), `OFS_TAG_LOW)) begin
               tag_low[k] <= wdata_in;
            end
         end
      end
   end

   // ****************************************************************
   // table entry words and search-valid flag
   // ****************************************************************
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         table_entry3_out <= 32'h00000000;
         table_entry4_out <= 32'h00000000;
         static_table_out <= 1'b0;
         search_valid_out <= 1'b0;
      end else if (ce_in) begin
         // the engines read the layout from the table select
         static_table_out <= static_table_sel_in;
         if (engine_load_in) begin
            table_entry3_out <= engine_word3_in;
            table_entry4_out <= engine_word4_in;
         end else if (wr_in && in_word(addr_in, `ADDR_ENTRY3)) begin
            table_entry3_out <= put_byte(table_entry3_out,
               addr_in[1:0], wdata_in);
         end else if (wr_in && in_word(addr_in, `ADDR_ENTRY4)) begin
            table_entry4_out <= put_byte(table_entry4_out,
               addr_in[1:0], wdata_in);
         end
         // a new result in the read cycle keeps the flag set
         if (search_valid_set_in) begin
            search_valid_out <= 1'b1;
         end else if (rd_in && (addr_in == `ADDR_ENTRY4_TOP)) begin
            search_valid_out <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   reg [7:0] next_rdata;

   always @* begin
      next_rdata = 8'h00;
      if (in_word(addr_in, `ADDR_ENTRY3)) begin
         next_rdata = byte_of(table_entry3_out, addr_in[1:0]);
      end else if (in_word(addr_in, `ADDR_ENTRY4)) begin
         next_rdata = byte_of(table_entry4_out, addr_in[1:0]);
      end else begin
         for (j = 0; j < NUM_PORTS; j = j + 1) begin
            if (hit(addr_in, port_num(j), `OFS_TAG_HIGH)) begin
               next_rdata = tag_high[j];
            end else if (hit(addr_in, port_num(j), `OFS_TAG_LOW)) begin
               next_rdata = tag_low[j];
            end else if (hit(addr_in, port_num(j), `OFS_WAKE_FLAGS)) begin
               next_rdata = {5'h00, wake_flags[3*j+:3]};
            end else if (hit(addr_in, port_num(j), `OFS_WAKE_ENABLE)) begin
               next_rdata = {5'h00, wake_enable[3*j+:3]};
            end else if (hit(addr_in, port_num(j), `OFS_IRQ_STATUS)) begin
               next_rdata = {6'h00, irq_status[2*j+:2]};
            end else if (hit(addr_in, port_num(j), `OFS_IRQ_MASK)) begin
               next_rdata = {6'h00, irq_mask[2*j+:2]};
            end
         end
      end
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_out <= 8'h00;
      end else if (ce_in) begin
         // data stand only in the cycle after the read strobe
         rdata_out <= read_ok ? next_rdata : 8'h00;
      end
   end

   // ****************************************************************
   // interrupt and power event outputs
   // ****************************************************************
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         port_irq_out <= {NUM_PORTS{1'b0}};
         irq_out <= 1'b0;
         power_event_output_out <= 1'b0;
      end else if (ce_in) begin
         port_irq_out <= irq_any;
         irq_out <= |irq_any;
         power_event_output_out <= |wake_any;
      end
   end
endmodule

`default_nettype wire

// ---- tb/port_tag_wake_irq_assertions.sv ----
// concurrent checks on the tag, wake event and interrupt register slice
`timescale 1ns/1ps
`default_nettype none
module port_tag_wake_irq_checker #(
   parameter NUM_PORTS = 3,
   parameter NUM_PHY_PORTS = 2
) (
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic [NUM_PORTS-1:0] magic_packet_in,
   input wire logic [NUM_PORTS-1:0] link_up_in,
   input wire logic [NUM_PORTS-1:0] energy_in,
   input wire logic [NUM_PORTS-1:0] phy_irq_in,
   input wire logic [NUM_PORTS-1:0] acl_irq_in,
   input wire logic engine_load_in,
   input wire logic [31:0] engine_word3_in,
   input wire logic [31:0] engine_word4_in,
   input wire logic search_valid_set_in,
   input wire logic [31:0] table_entry3_out,
   input wire logic [31:0] table_entry4_out,
   input wire logic search_valid_out,
   input wire logic [16*NUM_PORTS-1:0] default_tag_out,
   input wire logic [3*NUM_PORTS-1:0] pcp_out,
   input wire logic [NUM_PORTS-1:0] dei_out,
   input wire logic [12*NUM_PORTS-1:0] vid_out,
   input wire logic [NUM_PORTS-1:0] port_irq_out,
   input wire logic irq_out,
   input wire logic power_event_output_out
);
   // ****************************************************************
   // host access steps
   // ****************************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);
   sequence tag_high_wr;
      ce_in && wr_in && addr_in == 16'h1000;
   endsequence
   sequence mask_all_off;
      ce_in && wr_in && addr_in == 16'h101F && wdata_in[1:0] == 2'h3;
   endsequence
   // ****************************************************************
   // properties
   // ****************************************************************
   read_idle_zero_a: assert property (ce_in && !rd_in |=> !rdata_out)
      else $error("read data not zero after idle cycle");
   tag_high_write_a: assert property (tag_high_wr |=>
      default_tag_out[15:8] == $past(wdata_in))
      else $error("tag high byte not written");
   tag_hold_a: assert property (!(ce_in && wr_in) |=>
      $stable(default_tag_out)) else $error("tag changed without write");
   tag_fields_a: assert property (pcp_out[2:0] == default_tag_out[15:13]
      && dei_out[0] == default_tag_out[12]
      && vid_out[11:0] == default_tag_out[11:0])
      else $error("tag fields mismatch");
   wake_cause_a: assert property ($rose(power_event_output_out) |->
      $past(|{magic_packet_in, link_up_in, energy_in, wr_in}, 2))
      else $error("power event without cause");
   phy_port_irq_a: assert property ($rose(port_irq_out[0]) |->
      $past(acl_irq_in[0] | phy_irq_in[0] | wr_in, 2))
      else $error("port one interrupt without cause");
   mac_port_irq_a: assert property ($rose(port_irq_out[2]) |->
      $past(acl_irq_in[2] | wr_in, 2))
      else $error("mac port interrupt without cause");
   mask_off_irq_a: assert property (mask_all_off ##1 ce_in |=>
      !port_irq_out[0]) else $error("masked interrupt forwarded");
   irq_merge_a: assert property (irq_out == |port_irq_out)
      else $error("interrupt output not merged");
   search_clear_a: assert property (ce_in && rd_in &&
      addr_in == 16'h042F && !search_valid_set_in |=> !search_valid_out)
      else $error("search valid not cleared");
   engine_load_a: assert property (ce_in && engine_load_in |=>
      table_entry3_out == $past(engine_word3_in)
      && table_entry4_out == $past(engine_word4_in))
      else $error("entry words not loaded");
endmodule

bind port_tag_wake_irq_regs port_tag_wake_irq_checker #(
   .NUM_PORTS(NUM_PORTS),
   .NUM_PHY_PORTS(NUM_PHY_PORTS)
) checker_inst (
   .clock_in, .arst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .magic_packet_in, .link_up_in, .energy_in, .phy_irq_in,
   .acl_irq_in, .engine_load_in, .engine_word3_in, .engine_word4_in,
   .search_valid_set_in, .table_entry3_out, .table_entry4_out,
   .search_valid_out, .default_tag_out, .pcp_out, .dei_out, .vid_out,
   .port_irq_out, .irq_out, .power_event_output_out
);
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the port tag, wake event and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
   $display("BAD %0t got %h expected %h", $time, a, e); end end
module tb_top;
   logic clock_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1;
   logic wr_in = 1'b0, rd_in = 1'b0, static_table_sel_in = 1'b0;
   logic engine_load_in = 1'b0, search_valid_set_in = 1'b0;
   logic [15:0] addr_in = 16'h0000;
   logic [7:0] wdata_in = 8'h00, rdata_out;
   logic [2:0] magic_packet_in = 3'h0, link_up_in = 3'h0, energy_in = 3'h0;
   logic [2:0] phy_irq_in = 3'h0, acl_irq_in = 3'h0, dei_out, port_irq_out;
   logic [143:0] magic_dest_in = 144'h0;
   logic [47:0] switch_mac_in = 48'h0, default_tag_out;
   logic [31:0] engine_word3_in = 32'h0, engine_word4_in = 32'h0, seed;
   logic [31:0] table_entry3_out, table_entry4_out;
   logic static_table_out, search_valid_out, irq_out, power_event_output_out;
   logic [8:0] pcp_out;
   logic [35:0] vid_out;
   int bad_count = 0, comparisons = 0;
   port_tag_wake_irq_regs dut (
      .clock_in, .arst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .magic_packet_in, .magic_dest_in, .switch_mac_in,
      .link_up_in, .energy_in, .phy_irq_in, .acl_irq_in,
      .static_table_sel_in, .engine_load_in, .engine_word3_in,
      .engine_word4_in, .search_valid_set_in, .table_entry3_out,
      .table_entry4_out, .static_table_out, .search_valid_out,
      .default_tag_out, .pcp_out, .dei_out, .vid_out, .port_irq_out,
      .irq_out, .power_event_output_out
   );
   always #2 clock_in = ~clock_in;
   // ****************************************************************
   // helpers
   // ****************************************************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [15:0] pa(input int n, input logic [11:0] o);
      return {4'(n), o};
   endfunction
   function logic [11:0] exp_vid(input logic [7:0] h, input logic [7:0] l);
      return {h[3:0], l};
   endfunction
   task tk(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clock_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1;
      `CHK(rdata_out, e)
   endtask
   // one event on port g: energy, link, magic, acl, phy level toggle
   task ev(input int g, input int b, input bit hit);
      @(posedge clock_in);
      case (b)
         0: energy_in[g] <= 1'b1;
         1: link_up_in[g] <= 1'b1;
         2: begin
            magic_packet_in[g] <= 1'b1;
            magic_dest_in[48*g +: 48] <= hit ? switch_mac_in : ~switch_mac_in;
         end
         3: acl_irq_in[g] <= 1'b1;
         default: phy_irq_in[g] <= ~phy_irq_in[g];
      endcase
      @(posedge clock_in);
      {energy_in, link_up_in, magic_packet_in, acl_irq_in} <= 12'h000;
      tk(2);
   endtask
   task complete_run();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      int n, b;
      logic [7:0] h, l;
      logic [31:0] w3, w4;
      seed = 32'h00010B31;
      w3 = rnd();
      switch_mac_in = {w3[15:0], rnd()};
      tk(12);
      `CHK(vid_out, 36'h001001001)
      arst_n_in <= 1'b1;
      for (n = 1; n <= 3; n++) begin
         rd(pa(n, 12'h000), 8'h00);
         rd(pa(n, 12'h001), 8'h01);
         rd(pa(n, 12'h01F), 8'h00);
      end
      for (int i = 0; i < 12; i++) begin
         n = 1 + rnd() % 3;
         h = 8'(rnd());
         l = 8'(rnd());
         wr(pa(n, 12'h000), h);
         wr(pa(n, 12'h001), l);
         rd(pa(n, 12'h000), h);
         rd(pa(n, 12'h001), l);
         `CHK(pcp_out[3*n-3 +: 3], h[7:5])
         `CHK(dei_out[n-1], h[4])
         `CHK(vid_out[12*n-12 +: 12], exp_vid(h, l))
      end
      // a strobe while the clock enable is low must be lost
      wr(pa(1, 12'h000), 8'h3C);
      ce_in <= 1'b0;
      wr(pa(1, 12'h000), 8'hC3);
      ce_in <= 1'b1;
      rd(pa(1, 12'h000), 8'h3C);
      wr(16'h4000, 8'h5A);
      rd(16'h4000, 8'h00);
      rd(16'h0000, 8'h00);
      wr(pa(3, 12'h017), 8'hFF);
      rd(pa(3, 12'h017), 8'h04);
      wr(pa(3, 12'h017), 8'h00);
      for (b = 0; b < 3; b++) begin
         ev(0, b, 1'b1);
         `CHK(power_event_output_out, 1'b0)
         wr(pa(1, 12'h017), 8'(1 << b));
         tk(2);
         `CHK(power_event_output_out, 1'b1)
         rd(pa(1, 12'h013), 8'(1 << b));
         wr(pa(1, 12'h013), 8'(1 << b));
         tk(2);
         `CHK(power_event_output_out, 1'b0)
         rd(pa(1, 12'h013), 8'h00);
         wr(pa(1, 12'h017), 8'h00);
      end
      ev(1, 2, 1'b0);
      rd(pa(2, 12'h013), 8'h00);
      ev(2, 0, 1'b1);
      ev(2, 1, 1'b1);
      ev(2, 2, 1'b1);
      rd(pa(3, 12'h013), 8'h04);
      ev(0, 3, 1'b0);
      `CHK(irq_out, 1'b1)
      rd(pa(1, 12'h01B), 8'h01);
      rd(pa(1, 12'h01B), 8'h01);
      wr(pa(1, 12'h01F), 8'h03);
      tk(2);
      `CHK(irq_out, 1'b0)
      rd(pa(1, 12'h01B), 8'h00);
      ev(0, 3, 1'b0);
      `CHK(irq_out, 1'b0)
      wr(pa(1, 12'h01F), 8'h00);
      rd(pa(1, 12'h01B), 8'h00);
      ev(1, 4, 1'b0);
      `CHK(irq_out, 1'b1)
      rd(pa(2, 12'h01B), 8'h02);
      wr(pa(2, 12'h01F), 8'h02);
      tk(2);
      `CHK(irq_out, 1'b0)
      ev(1, 4, 1'b0);
      ev(2, 4, 1'b0);
      ev(2, 3, 1'b0);
      rd(pa(3, 12'h01B), 8'h01);
      w3 = rnd();
      w4 = rnd();
      @(posedge clock_in);
      {engine_load_in, static_table_sel_in, search_valid_set_in} <= 3'h7;
      {engine_word3_in, engine_word4_in} <= {w3, w4};
      @(posedge clock_in);
      {engine_load_in, search_valid_set_in} <= 2'h0;
      #1;
      `CHK(static_table_out, 1'b1)
      for (b = 0; b < 4; b++) begin
         rd(16'(16'h0428 + b), w3[8*b +: 8]);
         rd(16'(16'h042C + b), w4[8*b +: 8]);
         `CHK(search_valid_out, b != 3)
      end
      wr(16'h042A, 8'hC3);
      rd(16'h042A, 8'hC3);
      // reset in mid-run restores tag, masks and interrupt output
      arst_n_in <= 1'b0;
      tk(2);
      `CHK(irq_out, 1'b0)
      `CHK(vid_out, 36'h001001001)
      arst_n_in <= 1'b1;
      rd(pa(1, 12'h01F), 8'h00);
      rd(pa(1, 12'h000), 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
